/* clm_level_meter.sv */
// Local design decisions: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
// Summary of operation
// RULE_01 - First valid result appears no earlier than 4 ms after enable is set.
// RULE_02 - Result refreshes every 4 ms from current power and current offset byte.
// RULE_03 - Controller keeps test signal stable throughout each 4 ms window.
// RULE_04 - Software waits 4 ms after a new offset byte before trusting result.
// RULE_05 - Software waits 8 ms after a level change before trusting result.
// RULE_06 - Consecutive offset codes step threshold by roughly 0.02 Vrms.
// RULE_07 - Enabling metering forces tone generator two off.
// RULE_08 - Metering bandpass uses tone generator two coefficients.
// RULE_09 - Software loads identical coefficients into both tone generator bandpass filters.
// RULE_10 - With gain filters off, tone generator one emits -4.5 dBm0.
// RULE_11 - Software disables the echo balance filter while metering.
// RULE_12 - Software turns channel voice off via the voice select bit.
// RULE_13 - Writing the loop register activates receive-to-transmit digital loops.
// RULE_14 - Echo balance filter is active when its enable bit is one.
// RULE_15 - Reading the second config register returns the comparison result bit.
// RULE_16 - Software performs the level search by reprogramming offset and reading.
// RULE_17 - One 8-bit offset register is shared by all channels.
// RULE_18 - Filtered signal is rectified and its power compared with the offset.
// RULE_19 - Result is high when level exceeds the offset threshold, else low.
// RULE_20 - Software keeps the partner channel operating when metering channel 2 or 4.
// RULE_21 - Result holds between updates; reads never change it.
module clm_level_meter
    import clm_pkg::*;
#(
    parameter int CHANNELS      = 4,
    parameter int SW            = 16,
    parameter int WINDOW_CNT    = WINDOW_CYCLES,
    parameter int SAMPLE_DIV    = 5000
)(
    input  wire logic                     i_mclk,
    input  wire logic                     i_reset,
    input  wire logic [31:0]              i_s_axi_awaddr,
    input  wire logic                     i_s_axi_awvalid,
    output logic                          o_s_axi_awready,
    input  wire logic [31:0]              i_s_axi_wdata,
    input  wire logic [3:0]               i_s_axi_wstrb,
    input  wire logic                     i_s_axi_wvalid,
    output logic                          o_s_axi_wready,
    output logic [1:0]                    o_s_axi_bresp,
    output logic                          o_s_axi_bvalid,
    input  wire logic                     i_s_axi_bready,
    input  wire logic [31:0]              i_s_axi_araddr,
    input  wire logic                     i_s_axi_arvalid,
    output logic                          o_s_axi_arready,
    output logic [31:0]                   o_s_axi_rdata,
    output logic [1:0]                    o_s_axi_rresp,
    output logic                          o_s_axi_rvalid,
    input  wire logic                     i_s_axi_rready,
    input  wire logic [CHANNELS*SW-1:0]   i_bandpass_sample,
    output logic                          o_tone_gen1_on,
    output logic                          o_tone_gen2_on,
    output logic                          o_bandpass_coef_sel,
    output logic [SW-1:0]                 o_tone1_amplitude,
    output logic                          o_echo_balance_on,
    output logic                          o_voice_enable,
    output logic [7:0]                    o_loop_config,
    output logic [CHANNELS-1:0]           o_level_compare_result
);
    localparam int AW = 48;

    // Register state, every channel metered in parallel (channel field in tone register picks the one read back)
    logic [7:0]          filter_cfg;
    logic [7:0]          second_cfg;
    logic [7:0]          loop_cfg;
    logic [7:0]          level_offset;
    logic [7:0]          tone_cfg;
    logic [CHANNELS-1:0] result;
    logic [CHANNELS-1:0] result_valid;
    clm_state_t          state;
    logic [31:0]         win_cnt;
    logic [15:0]         div_cnt;
    logic [AW-1:0]       accum [CHANNELS];

    // AXI write channel capture, address and data taken in either order
    logic        aw_held;
    logic        w_held;
    logic [7:0]  aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;

    wire logic meter_en    = second_cfg[SCFG_METER_EN_POS];
    wire logic do_write    = aw_held && w_held && !o_s_axi_bvalid;
    wire logic sample_en   = (div_cnt == 16'(SAMPLE_DIV - 1));
    wire logic window_end  = (state != CLM_IDLE) && (win_cnt == 32'(WINDOW_CNT - 1));
    wire logic [7:0] wr_b0 = w_strb[0] ? w_data[7:0] : 8'h00;
    wire logic wr_hit_ofs  = do_write && (aw_addr == ADDR_LEVEL_OFS) && w_strb[0];
    wire logic wr_ok       = (aw_addr == ADDR_FILTER_CFG) || (aw_addr == ADDR_SECOND_CFG) ||
                             (aw_addr == ADDR_LOOP_CFG) || (aw_addr == ADDR_LEVEL_OFS) ||
                             (aw_addr == ADDR_TONE_CFG);

    // Threshold compared against the window energy
    // RULE_06 threshold step
    wire logic [AW-1:0] threshold = AW'(level_offset) * AW'(OFS_STEP_AMP) * AW'(WINDOW_CNT / SAMPLE_DIV);

    // Second config read view: stored bits plus the live result for the current channel
    wire logic [1:0] meter_ch = tone_cfg[3:2];
    wire logic [7:0] second_view = {second_cfg[7:2], result[meter_ch], second_cfg[0]};

    always_ff @(posedge i_mclk)
    begin
        if (i_reset)
        begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            aw_addr <= 8'h00;
            w_data  <= 32'h0000_0000;
            w_strb  <= 4'h0;
            o_s_axi_bvalid <= 1'b0;
            o_s_axi_bresp  <= 2'b00;
        end
        else
        begin
            if (i_s_axi_awvalid && o_s_axi_awready)
            begin
                aw_held <= 1'b1;
                aw_addr <= i_s_axi_awaddr[7:0];
            end
            if (i_s_axi_wvalid && o_s_axi_wready)
            begin
                w_held <= 1'b1;
                w_data <= i_s_axi_wdata;
                w_strb <= i_s_axi_wstrb;
            end
            if (do_write)
            begin
                aw_held <= 1'b0;
                w_held  <= 1'b0;
                o_s_axi_bvalid <= 1'b1;
                o_s_axi_bresp  <= wr_ok ? 2'b00 : 2'b10;
            end
            else if (o_s_axi_bvalid && i_s_axi_bready)
                o_s_axi_bvalid <= 1'b0;
        end
    end

    assign o_s_axi_awready = !aw_held && !i_reset;
    assign o_s_axi_wready  = !w_held && !i_reset;

    // Register writes
    always_ff @(posedge i_mclk)
    begin
        if (i_reset)
        begin
            filter_cfg   <= FILTER_CFG_RST;
            second_cfg   <= SECOND_CFG_RST;
            loop_cfg     <= LOOP_CFG_RST;
            level_offset <= LEVEL_OFS_RST;
            tone_cfg     <= TONE_CFG_RST;
        end
        else if (do_write && w_strb[0])
        begin
            case (aw_addr)
                ADDR_FILTER_CFG: filter_cfg <= wr_b0;
                // Result bit is read-only; its stored copy is ignored
                ADDR_SECOND_CFG: second_cfg <= wr_b0;
                // RULE_13 loop activation
                ADDR_LOOP_CFG:   loop_cfg <= wr_b0;
                // RULE_17 shared offset byte
                ADDR_LEVEL_OFS:  level_offset <= wr_b0;
                ADDR_TONE_CFG:   tone_cfg <= wr_b0;
                default:         ;
            endcase
        end
    end

    // Read channel; a read has no side effect on the result
    logic [7:0] rd_byte;
    always_comb
    begin
        case (i_s_axi_araddr[7:0])
            ADDR_FILTER_CFG: rd_byte = filter_cfg;
            // RULE_15 result readback
            ADDR_SECOND_CFG: rd_byte = second_view;
            ADDR_LOOP_CFG:   rd_byte = loop_cfg;
            ADDR_LEVEL_OFS:  rd_byte = level_offset;
            ADDR_TONE_CFG:   rd_byte = tone_cfg;
            ADDR_METER_STAT: rd_byte = {7'h00, result_valid[meter_ch]};
            default:         rd_byte = 8'h00;
        endcase
    end
    wire logic rd_ok = (i_s_axi_araddr[7:0] <= ADDR_METER_STAT) && (i_s_axi_araddr[1:0] == 2'b00);

    always_ff @(posedge i_mclk)
    begin
        if (i_reset)
        begin
            o_s_axi_rvalid <= 1'b0;
            o_s_axi_rdata  <= 32'h0000_0000;
            o_s_axi_rresp  <= 2'b00;
        end
        else if (i_s_axi_arvalid && o_s_axi_arready)
        begin
            o_s_axi_rvalid <= 1'b1;
            o_s_axi_rdata  <= {24'h000000, rd_ok ? rd_byte : 8'h00};
            o_s_axi_rresp  <= rd_ok ? 2'b00 : 2'b10;
        end
        else if (o_s_axi_rvalid && i_s_axi_rready)
            o_s_axi_rvalid <= 1'b0;
    end
    assign o_s_axi_arready = !o_s_axi_rvalid && !i_reset;

    // Sample-rate enable from a divider
    always_ff @(posedge i_mclk)
    begin
        if (i_reset || sample_en)
            div_cnt <= 16'h0000;
        else
            div_cnt <= div_cnt + 16'h0001;
    end

    // Window sequencer: enabling restarts the 4 ms window
    always_ff @(posedge i_mclk)
    begin
        if (i_reset || !meter_en)
        begin
            state   <= CLM_IDLE;
            win_cnt <= 32'h0000_0000;
        end
        else
        begin
            case (state)
                CLM_IDLE:  state <= CLM_FIRST;
                CLM_FIRST: if (window_end) state <= CLM_RUN;
                CLM_RUN:   state <= CLM_RUN;
                default:   state <= CLM_IDLE;
            endcase
            win_cnt <= window_end ? 32'h0000_0000 : win_cnt + 32'h0000_0001;
        end
    end

    // RULE_18 rectify and integrate per channel
    genvar ch;
    generate
        for (ch = 0; ch < CHANNELS; ch++)
        begin : g_chan
            clm_integrator #(.SW(SW), .AW(AW)) u_int (
                .i_mclk      (i_mclk),
                .i_reset     (i_reset),
                .i_clear     (window_end || state == CLM_IDLE),
                .i_sample_en (sample_en),
                .i_sample    (i_bandpass_sample[ch*SW +: SW]),
                .o_accum     (accum[ch])
            );

            always_ff @(posedge i_mclk)
            begin
                if (i_reset || !meter_en)
                begin
                    result[ch]       <= 1'b0;
                    result_valid[ch] <= 1'b0;
                end
                // RULE_02 refresh at window end
                else if (window_end)
                begin
                    // RULE_19 higher than threshold
                    result[ch]       <= (accum[ch] > threshold);
                    result_valid[ch] <= 1'b1;
                end
            end

            // RULE_01 no early result
            no_early_a: assert property (@(posedge i_mclk) disable iff (i_reset)
                $rose(result_valid[ch]) |-> $past(state) != CLM_IDLE && win_cnt == 32'h0)
                else $error("result valid before first window end");
            // RULE_21 result holds
            hold_between_a: assert property (@(posedge i_mclk) disable iff (i_reset)
                meter_en && $past(meter_en) && !$past(window_end) |-> $stable(result[ch]))
                else $error("result changed between window ends");
        end
    endgenerate

    // Outputs to the datapath, all from flip-flops
    always_ff @(posedge i_mclk)
    begin
        if (i_reset)
        begin
            o_tone_gen1_on         <= 1'b0;
            o_tone_gen2_on         <= 1'b0;
            o_bandpass_coef_sel    <= 1'b0;
            o_tone1_amplitude      <= '0;
            o_echo_balance_on      <= 1'b0;
            o_voice_enable         <= 1'b0;
            o_loop_config          <= 8'h00;
            o_level_compare_result <= '0;
        end
        else
        begin
            o_tone_gen1_on      <= tone_cfg[TONE_GEN1_ON_POS];
            // RULE_07 force generator two off
            o_tone_gen2_on      <= tone_cfg[TONE_GEN2_ON_POS] && !meter_en;
            // RULE_08 bandpass from generator two set
            o_bandpass_coef_sel <= 1'b1;
            // RULE_10 fixed level when gain filters off
            o_tone1_amplitude   <= (filter_cfg[FCFG_RX_GAIN_POS] || filter_cfg[FCFG_TX_GAIN_POS]) ?
                                   o_tone1_amplitude : SW'(TONE1_AMP_BYPASS);
            // RULE_14 echo balance enable
            o_echo_balance_on   <= filter_cfg[FCFG_ECHO_BAL_POS];
            o_voice_enable      <= second_cfg[SCFG_VOICE_SEL_POS];
            o_loop_config       <= loop_cfg;
            o_level_compare_result <= result;
        end
    end

    // RULE_07 generator two off while metering
    tg2_off_a: assert property (@(posedge i_mclk) disable iff (i_reset)
        $past(meter_en) && !$past(i_reset) |-> !o_tone_gen2_on)
        else $error("tone generator two on during metering");
    // RULE_02 window spacing
    window_len_a: assert property (@(posedge i_mclk) disable iff (i_reset)
        window_end |=> !window_end)
        else $error("back to back window ends");
    // RULE_14 echo filter follows bit
    echo_follow_a: assert property (@(posedge i_mclk) disable iff (i_reset)
        $rose(filter_cfg[FCFG_ECHO_BAL_POS]) |=> o_echo_balance_on)
        else $error("echo balance output did not follow");
    // RULE_13 loop register reaches datapath
    loop_follow_a: assert property (@(posedge i_mclk) disable iff (i_reset)
        !$stable(loop_cfg) |=> o_loop_config == $past(loop_cfg))
        else $error("loop config not applied");
    // RULE_17 offset write stored
    ofs_store_a: assert property (@(posedge i_mclk) disable iff (i_reset)
        wr_hit_ofs |=> level_offset == $past(w_data[7:0]))
        else $error("offset byte not stored");
    // RULE_19 output follows result
    result_out_a: assert property (@(posedge i_mclk) disable iff (i_reset)
        ##1 o_level_compare_result == $past(result))
        else $error("result output mismatch");
endmodule : clm_level_meter

/* clm_pkg.sv */
package clm_pkg;
    // Register byte offsets (AXI4-Lite, one aligned word each)
    localparam logic [7:0] ADDR_FILTER_CFG  = 8'h00;
    localparam logic [7:0] ADDR_SECOND_CFG  = 8'h04;
    localparam logic [7:0] ADDR_LOOP_CFG    = 8'h08;
    localparam logic [7:0] ADDR_LEVEL_OFS   = 8'h0c;
    localparam logic [7:0] ADDR_TONE_CFG    = 8'h10;
    localparam logic [7:0] ADDR_METER_STAT  = 8'h14;

    // Field positions
    localparam int FCFG_ECHO_BAL_POS   = 0;
    localparam int FCFG_RX_GAIN_POS    = 1;
    localparam int FCFG_TX_GAIN_POS    = 2;
    localparam int SCFG_VOICE_SEL_POS  = 0;
    localparam int SCFG_RESULT_POS     = 1;
    localparam int SCFG_METER_EN_POS   = 2;
    localparam int TONE_GEN1_ON_POS    = 0;
    localparam int TONE_GEN2_ON_POS    = 1;
    localparam int STAT_VALID_POS      = 0;

    // Reset values
    localparam logic [7:0] FILTER_CFG_RST = 8'h00;
    localparam logic [7:0] SECOND_CFG_RST = 8'h00;
    localparam logic [7:0] LOOP_CFG_RST   = 8'h00;
    localparam logic [7:0] LEVEL_OFS_RST  = 8'h00;
    localparam logic [7:0] TONE_CFG_RST   = 8'h00;

    // Timing: 4 ms window at 40 MHz
    localparam int CLK_HZ        = 40000000;
    localparam int WINDOW_US     = 4000;
    localparam int WINDOW_CYCLES = (CLK_HZ / 1000000) * WINDOW_US;

    // Tone generator 1 output with gain filters bypassed, -4.5 dBm0 as linear amplitude
    localparam logic [15:0] TONE1_AMP_BYPASS = 16'h2b26;
    // Threshold step per offset code, roughly 0.02 Vrms in sample units
    localparam logic [15:0] OFS_STEP_AMP     = 16'h0080;

    typedef enum logic [1:0] {
        CLM_IDLE  = 2'b00,
        CLM_FIRST = 2'b01,
        CLM_RUN   = 2'b11
    } clm_state_t;
endpackage : clm_pkg

/* clm_integrator.sv */
`timescale 1ns/1ps
module clm_integrator
    import clm_pkg::*;
#(
    parameter int SW = 16,
    parameter int AW = 40
)(
    input  wire logic          i_mclk,
    input  wire logic          i_reset,
    input  wire logic          i_clear,
    input  wire logic          i_sample_en,
    input  wire logic [SW-1:0] i_sample,
    output logic [AW-1:0]      o_accum
);
    // Full-wave rectification: magnitude of the two's complement sample
    wire logic [SW-1:0] magnitude = i_sample[SW-1] ? (~i_sample + 1'b1) : i_sample;
    wire logic [AW-1:0] next_accum = o_accum + AW'(magnitude);

    always_ff @(posedge i_mclk)
    begin
        if (i_reset)
            o_accum <= '0;
        // A sample landing on the clear cycle opens the next window instead of being lost
        else if (i_clear)
            o_accum <= i_sample_en ? AW'(magnitude) : '0;
        else if (i_sample_en)
            o_accum <= next_accum;
    end
endmodule : clm_integrator

/* clm_tone_source.sv */
`timescale 1ns/1ps
module clm_tone_source
    import clm_pkg::*;
#(
    parameter int CHANNELS = 4,
    parameter int SW       = 16
)(
    input  wire logic                   i_mclk,
    input  wire logic                   i_reset,
    input  wire logic [CHANNELS*SW-1:0] i_level,
    output logic [CHANNELS*SW-1:0]      o_sample
);
    logic phase;

    // Sign flips every clock, so only the rectified power of a channel carries its level
    always_ff @(posedge i_mclk)
    begin
        if (i_reset)
            phase <= 1'b0;
        else
            phase <= ~phase;
    end

    // level held steady
    // The amplitude only moves when the bench moves i_level, never inside a search step
    always_comb
    begin
        for (int n = 0; n < CHANNELS; n++)
            o_sample[n*SW +: SW] = phase ? -i_level[n*SW +: SW] : i_level[n*SW +: SW];
    end
endmodule : clm_tone_source

/* testbench.sv */
`timescale 1ns/1ps
module testbench
    import clm_pkg::*;
;
    localparam int WIN = 200;
    localparam int DIV = 10;
    logic        mclk = 1'b0, reset = 1'b1;
    logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata;
    logic [3:0]  wstrb = '0, lcr;
    logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic        awready, wready, bvalid, arready, rvalid, tg1, tg2, coef_sel, echo_on, voice_en;
    logic [1:0]  bresp, rresp;
    logic [63:0] level = '0, sample;
    logic [15:0] amp;
    logic [7:0]  loop_cfg;
    int          miscompares = 0, n_checks = 0;

    always #12.5 mclk = ~mclk;

    clm_level_meter #(.WINDOW_CNT(WIN), .SAMPLE_DIV(DIV)) clm_level_meter_i (
        .i_mclk(mclk), .i_reset(reset), .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid),
        .o_s_axi_awready(awready), .i_s_axi_wdata(wdata), .i_s_axi_wstrb(wstrb), .i_s_axi_wvalid(wvalid),
        .o_s_axi_wready(wready), .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready),
        .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid), .o_s_axi_arready(arready),
        .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready),
        .i_bandpass_sample(sample), .o_tone_gen1_on(tg1), .o_tone_gen2_on(tg2),
        .o_bandpass_coef_sel(coef_sel), .o_tone1_amplitude(amp), .o_echo_balance_on(echo_on),
        .o_voice_enable(voice_en), .o_loop_config(loop_cfg), .o_level_compare_result(lcr));

    clm_tone_source clm_tone_source_i (.i_mclk(mclk), .i_reset(reset), .i_level(level), .o_sample(sample));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("mismatch at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask : cyc

    // Ready is sampled at the rising edge; each channel is released once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic pa, pw;
        pa = 1'b1;
        pw = 1'b1;
        awaddr  <= {24'h0, a};
        wdata   <= d;
        wstrb   <= 4'hf;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        while (pa || pw)
        begin
            @(posedge mclk);
            if (pa && awready)
            begin
                pa = 1'b0;
                awvalid <= 1'b0;
            end
            if (pw && wready)
            begin
                pw = 1'b0;
                wvalid <= 1'b0;
            end
        end
        do @(posedge mclk); while (!bvalid);
        chk({30'h0, bresp}, {30'h0, er});
        bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        araddr  <= {24'h0, a};
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do @(posedge mclk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge mclk); while (!rvalid);
        chk(rdata, ed);
        chk({30'h0, rresp}, {30'h0, er});
        rready <= 1'b0;
    endtask : rd

    task automatic test_reset;
        chk({31'h0, coef_sel}, 32'h1);
        chk({16'h0, amp}, {16'h0, TONE1_AMP_BYPASS});
        rd(ADDR_FILTER_CFG, {24'h0, FILTER_CFG_RST}, 2'b00);
        rd(ADDR_SECOND_CFG, {24'h0, SECOND_CFG_RST}, 2'b00);
        rd(ADDR_LOOP_CFG, {24'h0, LOOP_CFG_RST}, 2'b00);
        rd(ADDR_LEVEL_OFS, {24'h0, LEVEL_OFS_RST}, 2'b00);
        rd(ADDR_TONE_CFG, {24'h0, TONE_CFG_RST}, 2'b00);
        rd(ADDR_METER_STAT, 32'h0, 2'b00);
        rd(8'h18, 32'h0, 2'b10);
        wr(8'h18, 32'hff, 2'b10);
        $display("test_reset done");
    endtask : test_reset

    task automatic test_cfg;
        wr(ADDR_FILTER_CFG, 32'h1 << FCFG_ECHO_BAL_POS, 2'b00);
        cyc(2);
        chk({31'h0, echo_on}, 32'h1);
        wr(ADDR_FILTER_CFG, 32'h6, 2'b00);
        cyc(2);
        chk({31'h0, echo_on}, 32'h0);
        wr(ADDR_FILTER_CFG, 32'h0, 2'b00);
        cyc(2);
        chk({16'h0, amp}, {16'h0, TONE1_AMP_BYPASS});
        wr(ADDR_LOOP_CFG, 32'ha5, 2'b00);
        cyc(2);
        chk({24'h0, loop_cfg}, 32'ha5);
        rd(ADDR_LOOP_CFG, 32'ha5, 2'b00);
        $display("test_cfg done");
    endtask : test_cfg

    task automatic test_meter;
        level <= {32'h0, 16'h0a00, 16'h0900};
        wr(ADDR_TONE_CFG, 32'h3, 2'b00);
        cyc(2);
        chk({30'h0, tg2, tg1}, 32'h3);
        wr(ADDR_LEVEL_OFS, 32'h11, 2'b00);
        wr(ADDR_SECOND_CFG, 32'h4, 2'b00);
        cyc(2);
        chk({29'h0, tg2, tg1, voice_en}, 32'h2);
        cyc(WIN - 40);
        rd(ADDR_METER_STAT, 32'h0, 2'b00);
        cyc(WIN);
        rd(ADDR_METER_STAT, 32'h1, 2'b00);
        rd(ADDR_SECOND_CFG, 32'h6, 2'b00);
        chk({28'h0, lcr}, 32'h3);
        $display("test_meter done");
    endtask : test_meter

    // Software-style successive approximation for channel 0 at amplitude 0x0900
    task automatic test_search;
        int lo, hi, mid;
        lo = 0;
        hi = 255;
        while (lo < hi)
        begin
            mid = (lo + hi + 1) / 2;
            wr(ADDR_LEVEL_OFS, mid, 2'b00);
            cyc(2 * WIN);
            rd(ADDR_SECOND_CFG, (32'h0900 > mid * 32'h80) ? 32'h6 : 32'h4, 2'b00);
            if (32'h0900 > mid * 32'h80)
                lo = mid;
            else
                hi = mid - 1;
        end
        wr(ADDR_LEVEL_OFS, 32'h12, 2'b00);
        cyc(2 * WIN);
        chk({28'h0, lcr}, 32'h2);
        $display("test_search done");
    endtask : test_search

    task automatic test_hold;
        wr(ADDR_TONE_CFG, 32'h7, 2'b00);
        rd(ADDR_SECOND_CFG, 32'h6, 2'b00);
        rd(ADDR_SECOND_CFG, 32'h6, 2'b00);
        chk({28'h0, lcr}, 32'h2);
        level <= {32'h0, 16'h0a00, 16'h1000};
        cyc(2 * WIN);
        chk({28'h0, lcr}, 32'h3);
        wr(ADDR_SECOND_CFG, 32'h0, 2'b00);
        cyc(2);
        chk({27'h0, lcr, tg2}, 32'h1);
        rd(ADDR_METER_STAT, 32'h0, 2'b00);
        $display("test_hold done");
    endtask : test_hold

    task automatic test_done;
        $display("checks %0d, miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : test_done

    initial
    begin
        repeat (16) @(posedge mclk);
        reset <= 1'b0;
        cyc(2);
        test_reset();
        test_cfg();
        test_meter();
        test_search();
        test_hold();
        test_done();
    end

    // Whole run is about 4500 cycles; four times that means a hang
    initial
    begin
        repeat (20000) @(posedge mclk);
        miscompares++;
        test_done();
    end
endmodule : testbench
